/* File: hw/nthf_timers_hash.sv */
// Tick counter, interrupt latency timer, multicast hash filter, switches
//
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Rate bit clear: tick counter steps once every 8 us.
// - Rate bit set: tick counter steps once every 2 us.
// - Tick counter cleared by hardware reset and by the host reset bit.
// - Hash filter read as eight bytes, lowest byte first, through one port.
// - Filter bits change only through the hash bit select command and hardware reset.
// - Select command with bit 10 clear clears the entry given by bits 5:0.
// - Hardware reset clears all 64 filter bits.
// - Switch bit 1 picks the ring rate: 0 is 16 Mbps, 1 is 4 Mbps.
// - Latency timer restarts from zero when the host interrupt asserts.
// - Running latency timer steps once every 2 us.
// - Latency timer halts at ffh and never wraps.
// - Pending latch blocks a restart; a fresh request restarts once clear.
// - Tick counter is read-only and free-running; writes are ignored.
// - The tick rate bit lives in the DMA control register.
module nthf_timers_hash
  import nthf_pkg::*;
(
  input wire logic clk_i, // 200 MHz clock
  input wire logic rst_i, // Sync reset, active high
  input wire nthf_wb_req_t wb_req_i, // Wishbone request
  output nthf_wb_rsp_t wb_rsp_o, // Wishbone answer
  output logic host_int_o, // Host interrupt level
  output logic ring_rate_4m_o, // Ring rate, 1 is 4 Mbps
  output logic mcast_filter_en_o, // Multicast filter enable
  output logic [63:0] mcast_hash_o // Filter bits to receive path
);

  function automatic logic idx_hit(input logic [15:0] adr,
                                   input logic [13:0] idx);
    idx_hit = (adr[15:2] == idx);
  endfunction : idx_hit

  // Bus request decode
  logic take;
  logic wr;
  logic rd;
  logic wr_dma;
  logic wr_glb;
  logic wr_hsel;
  logic wr_ireq;
  logic wr_cfg;
  logic wr_stat;
  logic wr_sw_lo;
  logic wr_sw_hi;
  logic rd_hash;
  logic hrst;

  assign take = wb_req_i.cyc & wb_req_i.stb & ~wb_rsp_o.ack;
  assign wr = take & wb_req_i.we;
  assign rd = take & ~wb_req_i.we;
  assign wr_dma = wr & idx_hit(wb_req_i.adr, IDX_DMA_CTRL) & wb_req_i.sel[0];
  assign wr_glb = wr & idx_hit(wb_req_i.adr, IDX_GLB_RST) & wb_req_i.sel[0];
  assign wr_hsel = wr & idx_hit(wb_req_i.adr, IDX_HASH_SEL) &
                   (&wb_req_i.sel[1:0]);
  assign wr_ireq = wr & idx_hit(wb_req_i.adr, IDX_INT_REQ);
  assign wr_cfg = wr & idx_hit(wb_req_i.adr, IDX_CFG_CMD) & wb_req_i.sel[0];
  assign wr_stat = wr & idx_hit(wb_req_i.adr, IDX_INT_STAT) & wb_req_i.sel[0];
  assign wr_sw_lo = wr & idx_hit(wb_req_i.adr, IDX_SWITCH) & wb_req_i.sel[0];
  assign wr_sw_hi = wr & idx_hit(wb_req_i.adr, IDX_SWITCH) & wb_req_i.sel[1];
  assign rd_hash = rd & idx_hit(wb_req_i.adr, IDX_HASH);
  assign hrst = wr_glb & wb_req_i.dat[GLB_HOST_RST_BIT];

  // Control registers
  logic rate_r;
  logic rate_nxt;
  logic [CFG_W-1:0] cfg_r;
  logic [CFG_W-1:0] cfg_nxt;
  logic [15:0] sw_r;
  logic [15:0] sw_nxt;
  logic latch_r;
  logic latch_nxt;

  always_comb begin
    rate_nxt = rate_r;
    cfg_nxt = cfg_r;
    sw_nxt = sw_r;
    latch_nxt = latch_r;
    if (wr_dma) begin
      rate_nxt = wb_req_i.dat[DMA_RATE_BIT];
    end
    if (wr_cfg) begin
      cfg_nxt = wb_req_i.dat[CFG_W-1:0];
    end
    if (wr_sw_lo) begin
      sw_nxt[7:0] = wb_req_i.dat[7:0];
    end
    if (wr_sw_hi) begin
      sw_nxt[15:8] = wb_req_i.dat[15:8];
    end
    // Acknowledge clears; a request in the same cycle wins
    if (wr_stat && wb_req_i.dat[STAT_LATCH_BIT]) begin
      latch_nxt = 1'b0;
    end
    if (wr_ireq) begin
      latch_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rate_r <= 1'b0;
      cfg_r <= CFG_RST;
      sw_r <= SWITCH_RST;
      latch_r <= 1'b0;
      host_int_o <= 1'b0;
      ring_rate_4m_o <= SWITCH_RST[SW_RATE_BIT];
      mcast_filter_en_o <= CFG_RST[CFG_HASH_EN_BIT];
    end else begin
      rate_r <= rate_nxt;
      cfg_r <= cfg_nxt;
      sw_r <= sw_nxt;
      latch_r <= latch_nxt;
      host_int_o <= latch_nxt;
      ring_rate_4m_o <= sw_nxt[SW_RATE_BIT];
      mcast_filter_en_o <= cfg_nxt[CFG_HASH_EN_BIT];
    end
  end

  // Free-running tick counter
  logic [15:0] free_r;
  logic [15:0] free_nxt;
  logic [PRE_W-1:0] tpre_r;
  logic [PRE_W-1:0] tpre_nxt;
  logic [PRE_W-1:0] tlast;
  logic tick;

  always_comb begin
    tlast = rate_r ? FAST_LAST : SLOW_LAST;
    tick = (tpre_r >= tlast);
    free_nxt = free_r;
    tpre_nxt = tpre_r + PRE_W'(1);
    if (hrst) begin
      free_nxt = FREE_RST;
      tpre_nxt = '0;
    end else if (tick) begin
      tpre_nxt = '0;
      free_nxt = free_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      free_r <= FREE_RST;
      tpre_r <= '0;
    end else begin
      free_r <= free_nxt;
      tpre_r <= tpre_nxt;
    end
  end

  // Multicast hash filter and its byte read pointer
  logic [63:0] hash_r;
  logic [63:0] hash_nxt;
  logic [2:0] hptr_r;
  logic [2:0] hptr_nxt;
  logic [7:0] hbyte [8];
  logic [7:0] hcur;

  for (genvar g = 0; g < 8; g++) begin : g_hbyte
    assign hbyte[g] = hash_r[8*g +: 8];
  end

  assign hcur = hbyte[hptr_r];

  always_comb begin
    hash_nxt = hash_r;
    hptr_nxt = hptr_r;
    if (wr_hsel) begin
      hash_nxt[wb_req_i.dat[HSEL_IDX_MSB:0]] =
        wb_req_i.dat[HSEL_SET_BIT];
    end
    if (rd_hash) begin
      hptr_nxt = hptr_r + 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hash_r <= HASH_RST;
      hptr_r <= 3'h0;
      mcast_hash_o <= HASH_RST;
    end else begin
      hash_r <= hash_nxt;
      hptr_r <= hptr_nxt;
      mcast_hash_o <= hash_nxt;
    end
  end

  // Interrupt latency timer
  nthf_lat_st_t lst_r;
  nthf_lat_st_t lst_nxt;
  logic [7:0] lat_r;
  logic [7:0] lat_nxt;
  logic [PRE_W-1:0] lpre_r;
  logic [PRE_W-1:0] lpre_nxt;
  logic lat_start;

  assign lat_start = latch_nxt & ~latch_r;

  always_comb begin
    lst_nxt = lst_r;
    lat_nxt = lat_r;
    lpre_nxt = lpre_r;
    case (lst_r)
      LT_IDLE: begin
        lpre_nxt = '0;
      end
      LT_RUN: begin
        if (lpre_r == FAST_LAST) begin
          lpre_nxt = '0;
          lat_nxt = lat_r + 8'h01;
          if (lat_r == LAT_SAT - 8'h01) begin
            lst_nxt = LT_HALT;
          end
        end else begin
          lpre_nxt = lpre_r + PRE_W'(1);
        end
      end
      LT_HALT: begin
        lpre_nxt = '0;
      end
      default: begin
        lst_nxt = LT_IDLE;
      end
    endcase
    if (lat_start) begin
      lst_nxt = LT_RUN;
      lat_nxt = LAT_RST;
      lpre_nxt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lst_r <= LT_IDLE;
      lat_r <= LAT_RST;
      lpre_r <= '0;
    end else begin
      lst_r <= lst_nxt;
      lat_r <= lat_nxt;
      lpre_r <= lpre_nxt;
    end
  end

  // Wishbone answer: ack one cycle after the request is taken
  nthf_wb_rsp_t rsp_nxt;
  logic [31:0] rdat;

  always_comb begin
    rdat = '0;
    if (idx_hit(wb_req_i.adr, IDX_LAT_TIMER)) begin
      rdat[7:0] = lat_r;
    end else if (idx_hit(wb_req_i.adr, IDX_CONFIG)) begin
      rdat[CFG_W-1:0] = cfg_r;
    end else if (idx_hit(wb_req_i.adr, IDX_FREE)) begin
      rdat[15:0] = free_r;
    end else if (idx_hit(wb_req_i.adr, IDX_HASH)) begin
      rdat[7:0] = hcur;
    end else if (idx_hit(wb_req_i.adr, IDX_SWITCH)) begin
      rdat[15:0] = sw_r;
    end else if (idx_hit(wb_req_i.adr, IDX_DMA_CTRL)) begin
      rdat[DMA_RATE_BIT] = rate_r;
    end else if (idx_hit(wb_req_i.adr, IDX_INT_STAT)) begin
      rdat[STAT_LATCH_BIT] = latch_r;
    end
    rsp_nxt.ack = take;
    rsp_nxt.dat = rd ? rdat : 32'h0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_rsp_o <= '0;
    end else begin
      wb_rsp_o <= rsp_nxt;
    end
  end

  // Checks
  a_tick_slow_step: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!rate_r && tpre_r == SLOW_LAST && !hrst)
      |=> free_r == $past(free_r) + 16'h0001)
    else $error("slow tick did not step");

  a_tick_fast_step: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rate_r && tpre_r == FAST_LAST && !hrst)
      |=> free_r == $past(free_r) + 16'h0001)
    else $error("fast tick did not step");

  a_tick_host_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    hrst |=> (free_r == FREE_RST) && (tpre_r == '0))
    else $error("host reset left tick counter");

  a_tick_hold_between: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (!tick && !hrst) |=> $stable(free_r))
    else $error("tick counter moved off a tick");

  a_tick_wrap_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (free_r == 16'hffff && tick && !hrst) |=> free_r == 16'h0000)
    else $error("tick counter did not wrap");

  a_hash_read_order: assert property (
    @(posedge clk_i) disable iff (rst_i)
    rd_hash |=> (hptr_r == $past(hptr_r) + 3'h1) &&
      (wb_rsp_o.dat[7:0] == $past(hcur)) && wb_rsp_o.ack)
    else $error("hash byte order wrong");

  a_hash_only_cmd: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !wr_hsel |=> $stable(hash_r))
    else $error("hash changed without command");

  a_hash_bit_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_hsel && !wb_req_i.dat[HSEL_SET_BIT])
      |=> !hash_r[$past(wb_req_i.dat[HSEL_IDX_MSB:0])])
    else $error("hash entry not cleared");

  a_hash_reset_zero: assert property (
    @(posedge clk_i)
    rst_i |=> (hash_r == HASH_RST) && (mcast_hash_o == HASH_RST))
    else $error("hash not cleared by reset");

  a_ring_rate_bit: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wr_sw_lo |=> ring_rate_4m_o == $past(wb_req_i.dat[SW_RATE_BIT]))
    else $error("ring rate does not follow switch");

  a_lat_restart_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $rose(host_int_o) |-> (lat_r == LAT_RST) && (lst_r == LT_RUN))
    else $error("latency timer not restarted");

  a_lat_step_rate: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (lst_r == LT_RUN && lpre_r == FAST_LAST && !lat_start)
      |=> lat_r == $past(lat_r) + 8'h01)
    else $error("latency timer step wrong");

  a_lat_saturate: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (lat_r == LAT_SAT && !lat_start) |=> lat_r == LAT_SAT)
    else $error("latency timer wrapped");

  a_lat_no_restart: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (latch_r && wr_ireq) |=> (lst_r == $past(lst_nxt)) &&
      (lat_r == $past(lat_nxt)) && !$rose(host_int_o))
    else $error("latency timer restarted while pending");

endmodule : nthf_timers_hash

`default_nettype wire

/* File: hw/nthf_pkg.sv */
// Register map, constants and carrier types of the timers and hash filter
package nthf_pkg;

  // Clock rate and tick periods
  localparam int CLK_MHZ = 200;
  localparam int SLOW_US = 8;
  localparam int FAST_US = 2;
  localparam int SLOW_CYC = SLOW_US * CLK_MHZ;
  localparam int FAST_CYC = FAST_US * CLK_MHZ;
  localparam int PRE_W = 11;
  localparam logic [PRE_W-1:0] SLOW_LAST = PRE_W'(SLOW_CYC - 1);
  localparam logic [PRE_W-1:0] FAST_LAST = PRE_W'(FAST_CYC - 1);

  // Register indices; the byte address is four times the index
  localparam logic [13:0] IDX_LAT_TIMER = 14'h001a;
  localparam logic [13:0] IDX_CONFIG = 14'h001d;
  localparam logic [13:0] IDX_FREE = 14'h0022;
  localparam logic [13:0] IDX_HASH = 14'h0028;
  localparam logic [13:0] IDX_SWITCH = 14'h1c88;
  localparam logic [13:0] IDX_DMA_CTRL = 14'h0040;
  localparam logic [13:0] IDX_GLB_RST = 14'h0041;
  localparam logic [13:0] IDX_HASH_SEL = 14'h0042;
  localparam logic [13:0] IDX_INT_REQ = 14'h0043;
  localparam logic [13:0] IDX_CFG_CMD = 14'h0044;
  localparam logic [13:0] IDX_INT_STAT = 14'h0045;

  // Field positions
  localparam int DMA_RATE_BIT = 0;
  localparam int GLB_HOST_RST_BIT = 0;
  localparam int HSEL_SET_BIT = 10;
  localparam int HSEL_IDX_MSB = 5;
  localparam int CFG_W = 4;
  localparam int CFG_HASH_EN_BIT = 0;
  localparam int STAT_LATCH_BIT = 0;
  localparam int SW_RATE_BIT = 1;

  // Values after reset and limits
  localparam logic [15:0] SWITCH_RST = 16'h3201;
  localparam logic [15:0] FREE_RST = 16'h0000;
  localparam logic [63:0] HASH_RST = 64'h0;
  localparam logic [CFG_W-1:0] CFG_RST = 4'h0;
  localparam logic [7:0] LAT_RST = 8'h00;
  localparam logic [7:0] LAT_SAT = 8'hff;

  typedef enum logic [1:0] {
    LT_IDLE = 2'b00,
    LT_RUN = 2'b01,
    LT_HALT = 2'b10
  } nthf_lat_st_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [15:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } nthf_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } nthf_wb_rsp_t;

endpackage : nthf_pkg

/* File: test/nthf_host_bfm.sv */
// Host driver model: classic Wishbone master with bounded waits
`timescale 1ns/1ps
`default_nettype none
module nthf_host_bfm
  import nthf_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire nthf_wb_rsp_t rsp_i, // Slave answer
  output nthf_wb_req_t req_o // Master request
);
  int lost = 0;

  initial req_o = '0;

  // Called just after a rising edge; returns one idle cycle after ack
  task automatic xfer(input logic we, input logic [13:0] idx,
                      input logic [3:0] sel, input logic [31:0] d);
    int n;
    n = 0;
    req_o <= '{1'b1, 1'b1, we, {idx, 2'b00}, sel, d};
    @(posedge clk_i);
    while (rsp_i.ack !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (rsp_i.ack !== 1'b1) begin
      lost++;
    end
    // Released lines show the inverse, not the last value
    req_o <= '{1'b0, 1'b0, ~we, ~{idx, 2'b00}, ~sel, ~d};
    @(posedge clk_i);
  endtask : xfer
endmodule : nthf_host_bfm
`default_nettype wire

/* File: test/test_nthf_timers_hash.sv */
// Self-checking bench of the timers and hash filter block
`timescale 1ns/1ps
`default_nettype none
module test_nthf_timers_hash;
  import nthf_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  nthf_wb_req_t wb_req;
  nthf_wb_rsp_t wb_rsp;
  logic host_int;
  logic rate_4m;
  logic filt_en;
  logic [63:0] hash_bits;
  logic [31:0] exp_q[$];
  logic [63:0] hmodel = 64'h0;
  logic [5:0] hidx;
  logic [15:0] sw;
  int bad_count = 0;
  int compares = 0;

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  nthf_timers_hash uut (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req),
    .wb_rsp_o(wb_rsp), .host_int_o(host_int), .ring_rate_4m_o(rate_4m),
    .mcast_filter_en_o(filt_en), .mcast_hash_o(hash_bits));
  nthf_host_bfm host (.clk_i(clk_i), .rsp_i(wb_rsp), .req_o(wb_req));

  task automatic chk(input string what, input logic [63:0] e,
                     input logic [63:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic report_and_stop();
    bad_count += host.lost;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [13:0] i, input logic [3:0] s,
                    input logic [31:0] d);
    host.xfer(1'b1, i, s, d);
  endtask : wr

  task automatic rd(input logic [13:0] i, input logic [31:0] e);
    exp_q.push_back(e);
    host.xfer(1'b0, i, 4'hf, 32'h0);
  endtask : rd

  task automatic rd_hash();
    for (int b = 0; b < 8; b++) begin
      rd(IDX_HASH, {24'h0, hmodel[8*b +: 8]});
    end
  endtask : rd_hash

  // Read answers are compared against the oldest note
  always @(posedge clk_i) begin
    if (wb_rsp.ack === 1'b1 && wb_req.we === 1'b0) begin
      if (exp_q.size() == 0) begin
        chk("spare read", 64'h1, 64'h0);
      end else begin
        chk("read data", {32'h0, exp_q.pop_front()}, {32'h0, wb_rsp.dat});
      end
    end
    if (host.lost != 0) begin
      report_and_stop();
    end
  end

  initial begin
    void'($urandom(38208));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("ring rate", 64'h0, {63'h0, rate_4m});
    chk("filter bits", 64'h0, hash_bits);
    rd(IDX_SWITCH, {16'h0, SWITCH_RST});
    rd(IDX_LAT_TIMER, 32'h0);
    rd(14'h3ff0, 32'h0);
    rd_hash();
    for (int k = 0; k < 8; k++) begin
      hidx = (k == 0) ? 6'h00 : (k == 1) ? 6'h3f : 6'($urandom());
      hmodel[hidx] = 1'b1;
      wr(IDX_HASH_SEL, 4'h3, {21'h0, 1'b1, 4'h0, hidx});
    end
    // Colliding address hits a bit that is already set
    wr(IDX_HASH_SEL, 4'h3, {21'h0, 1'b1, 4'h0, 6'h3f});
    chk("filter bits", hmodel, hash_bits);
    wr(IDX_HASH, 4'hf, 32'hffff_ffff);
    chk("filter bits", hmodel, hash_bits);
    rd_hash();
    hmodel[hidx] = 1'b0;
    wr(IDX_HASH_SEL, 4'h3, {26'h0, hidx});
    chk("filter bits", hmodel, hash_bits);
    rd_hash();
    wr(IDX_CFG_CMD, 4'h1, 32'h1);
    chk("filter enable", 64'h1, {63'h0, filt_en});
    rd(IDX_CONFIG, 32'h1);
    for (int k = 0; k < 2; k++) begin
      sw = 16'($urandom());
      sw[1] = k[0];
      wr(IDX_SWITCH, 4'h3, {16'h0, sw});
      chk("ring rate", {63'h0, sw[1]}, {63'h0, rate_4m});
      rd(IDX_SWITCH, {16'h0, sw});
    end
    wr(IDX_GLB_RST, 4'h1, 32'h1);
    wr(IDX_FREE, 4'hf, 32'h1234);
    repeat (3 * SLOW_CYC + SLOW_CYC / 2) @(posedge clk_i);
    rd(IDX_FREE, 32'd3);
    wr(IDX_DMA_CTRL, 4'h1, 32'h1);
    rd(IDX_DMA_CTRL, 32'h1);
    wr(IDX_GLB_RST, 4'h1, 32'h1);
    repeat (5 * FAST_CYC + FAST_CYC / 2) @(posedge clk_i);
    rd(IDX_FREE, 32'd5);
    wr(IDX_INT_REQ, 4'h1, 32'h1);
    chk("host int", 64'h1, {63'h0, host_int});
    repeat (3 * FAST_CYC + FAST_CYC / 2) @(posedge clk_i);
    rd(IDX_LAT_TIMER, 32'd3);
    wr(IDX_INT_REQ, 4'h1, 32'h1);
    repeat (FAST_CYC) @(posedge clk_i);
    rd(IDX_LAT_TIMER, 32'd4);
    wr(IDX_INT_STAT, 4'h1, 32'h1);
    chk("host int", 64'h0, {63'h0, host_int});
    rd(IDX_INT_STAT, 32'h0);
    wr(IDX_INT_REQ, 4'h1, 32'h1);
    repeat (FAST_CYC / 2) @(posedge clk_i);
    rd(IDX_LAT_TIMER, 32'h0);
    // Second reset in mid-run
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    hmodel = 64'h0;
    chk("filter bits", 64'h0, hash_bits);
    rd_hash();
    rd(IDX_FREE, 32'h0);
    chk("ring rate", 64'h0, {63'h0, rate_4m});
    chk("filter enable", 64'h0, {63'h0, filt_en});
    chk("host int", 64'h0, {63'h0, host_int});
    chk("pending reads", 64'h0, 64'(exp_q.size()));
    report_and_stop();
  end
endmodule : test_nthf_timers_hash
`default_nettype wire
